// ### common/refsel_regs.svh
// register offsets, field positions, reset values and the pair count for the clock control block
// Summary of operation
// - pin switching needs auto off, pins enabled
// - select pins pick input a, b, c, holdover
// - select pins default to inputs
// - align event phase-aligns enabled outputs
// - new delay values apply on align
// - align pin forces frame mux continuous
// - align pin may hold outputs low
// - polarity setting sets align pin sense
// - polarity invert toggle makes align event
// - lock pins show outer, inner lock
// - lock pin high locked, low lost
// - each pair has format selection
// - cmos pair outputs normal, inverted, off
`ifndef REFSEL_REGS_SVH
`define REFSEL_REGS_SVH
`define REG_SEL_CTRL 8'h00
`define REG_ALIGN_CTRL 8'h04
`define REG_FRAME_CTRL 8'h08
`define REG_STATUS 8'h0C
`define REG_DELAY_BASE 8'h10
`define REG_FMT_BASE 8'h30
`define NUM_PAIRS 7
`define SEL_AUTO_BIT 0
`define SEL_PINEN_BIT 1
`define SEL_PINPOL_BIT 2
`define SEL_TYPE0_LSB 4
`define SEL_TYPE1_LSB 8
`define ALIGN_POL_BIT 0
`define ALIGN_INV_BIT 1
`define ALIGN_HOLDLOW_BIT 2
`define FRAME_MUX_LSB 0
`define FRAME_REQEN_BIT 4
`define FRAME_MUX_CONT 2'h3
`define SEL_CTRL_RESET 32'h0000_0002
`define SELECT_TYPE_INPUT_MAX 3'h3
`endif

// ### common/refsel_pkg.sv
// types shared by the clock control block
package refsel_pkg;
  typedef enum logic [1:0] {SRC_A, SRC_B, SRC_C, SRC_HOLDOVER} ref_source_t;
  typedef enum logic [2:0] {FMT_OFF, FMT_LVDS, FMT_HSDS, FMT_LVPECL, FMT_LCPECL, FMT_CML,
    FMT_LVCMOS} pair_format_t;
  typedef enum logic [1:0] {CMOS_OFF, CMOS_NORMAL, CMOS_INVERTED} cmos_mode_t;
endpackage

// ### verilog/pin_sync.sv
// two-flop synchroniser for asynchronous pins
module pin_sync #(parameter int WIDTH = 1) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] stage1;
  // first stage read only by the second
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stage1 <= '0;
      o_sync <= '0;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end
endmodule // pin_sync

// ### verilog/pair_format.sv
// one output pair: format and lvcmos leg modes
module pair_format
  import refsel_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [7:0] i_cfg,
  input wire logic i_hold_low,
  output logic o_enable_p,
  output logic o_enable_n,
  output logic o_invert_p,
  output logic o_invert_n,
  output logic o_force_low
);
  pair_format_t fmt;
  cmos_mode_t mode_p;
  cmos_mode_t mode_n;
  assign fmt = pair_format_t'(i_cfg[2:0]);
  assign mode_p = cmos_mode_t'(i_cfg[5:4]);
  assign mode_n = cmos_mode_t'(i_cfg[7:6]);
  // legs: differential formats drive both, cmos legs separately
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_enable_p <= 1'b0;
      o_enable_n <= 1'b0;
      o_invert_p <= 1'b0;
      o_invert_n <= 1'b0;
      o_force_low <= 1'b0;
    end else begin
      o_force_low <= i_hold_low;
      if (fmt == FMT_LVCMOS) begin
        o_enable_p <= (mode_p == CMOS_NORMAL) || (mode_p == CMOS_INVERTED);
        o_enable_n <= (mode_n == CMOS_NORMAL) || (mode_n == CMOS_INVERTED);
        o_invert_p <= mode_p == CMOS_INVERTED;
        o_invert_n <= mode_n == CMOS_INVERTED;
      end else begin
        o_enable_p <= fmt != FMT_OFF;
        o_enable_n <= fmt != FMT_OFF;
        o_invert_p <= 1'b0;
        o_invert_n <= 1'b1; // true differential
      end
    end
  end
endmodule // pair_format

// ### verilog/ref_select_and_sync_control.sv
// top: wishbone registers, reference selection, alignment and lock status
`include "refsel_regs.svh"
module ref_select_and_sync_control (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_ref_select_bit0,
  input wire logic i_ref_select_bit1,
  input wire logic i_align_pin,
  input wire logic i_outer_loop_lock,
  input wire logic i_inner_loop_lock,
  output refsel_pkg::ref_source_t o_active_source,
  output logic o_select_bit0_oe,
  output logic o_select_bit1_oe,
  output logic o_align_pulse,
  output logic [1:0] o_frame_ref_source_mux,
  output logic [`NUM_PAIRS*16-1:0] o_pair_delay,
  output logic [`NUM_PAIRS-1:0] o_pair_enable_p,
  output logic [`NUM_PAIRS-1:0] o_pair_enable_n,
  output logic [`NUM_PAIRS-1:0] o_pair_invert_p,
  output logic [`NUM_PAIRS-1:0] o_pair_invert_n,
  output logic [`NUM_PAIRS-1:0] o_pair_force_low,
  output logic o_lock_status_out_a,
  output logic o_lock_status_out_b
);
  import refsel_pkg::*;

  logic rst_meta;
  logic rst_n;
  logic [31:0] sel_ctrl;
  logic [2:0] align_ctrl;
  logic [4:0] frame_ctrl;
  logic [15:0] delay_pending [`NUM_PAIRS];
  logic [7:0] pair_cfg [`NUM_PAIRS];
  logic [4:0] pins_sync;
  logic pin_sel0;
  logic pin_sel1;
  logic align_raw;
  logic outer_lock;
  logic inner_lock;
  logic align_asserted;
  logic align_asserted_q;
  logic inv_q;
  logic align_event;
  logic pin_mode;
  logic wb_hit;
  logic [31:0] next_rdata;
  ref_source_t last_source;

  // merge byte lanes into an old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] din,
      input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[b*8 +: 8] = din[b*8 +: 8];
    end
    return r;
  endfunction

  // which pair slot an address names, NUM_PAIRS when none
  function automatic logic [3:0] slot(input logic [7:0] adr, input logic [7:0] base);
    logic [7:0] d;
    d = adr - base;
    if (adr >= base && d[1:0] == 2'h0 && d[7:2] < 6'(`NUM_PAIRS)) return 4'(d[7:2]);
    return 4'(`NUM_PAIRS);
  endfunction

  // a select pin type in the input range leaves the pin an input
  function automatic logic is_input_type(input logic [2:0] pin_type);
    return pin_type <= `SELECT_TYPE_INPUT_MAX;
  endfunction

  // reset release through two flops
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // every pin and external lock level synchronised first
  pin_sync #(.WIDTH(5)) u_pins (
    .i_clock(i_clock),
    .i_rst_n(rst_n),
    .i_async({i_inner_loop_lock, i_outer_loop_lock, i_align_pin, i_ref_select_bit1,
      i_ref_select_bit0}),
    .o_sync(pins_sync)
  );
  assign pin_sel0 = pins_sync[0];
  assign pin_sel1 = pins_sync[1];
  assign align_raw = pins_sync[2];
  assign outer_lock = pins_sync[3];
  assign inner_lock = pins_sync[4];

  // single-cycle classic wishbone answer, ack dropped the cycle after
  assign wb_hit = i_wb_cyc && i_wb_stb && !o_wb_ack;
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) o_wb_ack <= 1'b0;
    else o_wb_ack <= wb_hit;
  end

  // control register writes; select pins stay inputs by default
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      sel_ctrl <= `SEL_CTRL_RESET;
      align_ctrl <= 3'h0;
      frame_ctrl <= 5'h00;
    end else if (wb_hit && i_wb_we) begin
      if (i_wb_adr == `REG_SEL_CTRL) sel_ctrl <= merge(sel_ctrl, i_wb_dat, i_wb_sel);
      if (i_wb_adr == `REG_ALIGN_CTRL && i_wb_sel[0]) align_ctrl <= i_wb_dat[2:0];
      if (i_wb_adr == `REG_FRAME_CTRL && i_wb_sel[0]) frame_ctrl <= i_wb_dat[4:0];
    end
  end

  // pending delays and pair formats
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `NUM_PAIRS; i++) begin
        delay_pending[i] <= 16'h0000;
        pair_cfg[i] <= 8'h00;
      end
    end else if (wb_hit && i_wb_we) begin
      for (int i = 0; i < `NUM_PAIRS; i++) begin
        if (slot(i_wb_adr, `REG_DELAY_BASE) == 4'(i)) begin
          delay_pending[i] <= 16'(merge({16'h0000, delay_pending[i]}, i_wb_dat, i_wb_sel));
        end
        if (slot(i_wb_adr, `REG_FMT_BASE) == 4'(i) && i_wb_sel[0]) begin
          pair_cfg[i] <= i_wb_dat[7:0];
        end
      end
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (i_wb_adr)
      `REG_SEL_CTRL: next_rdata = sel_ctrl;
      `REG_ALIGN_CTRL: next_rdata = {29'h0, align_ctrl};
      `REG_FRAME_CTRL: next_rdata = {27'h0, frame_ctrl};
      `REG_STATUS: next_rdata = {24'h0, 2'h0, o_frame_ref_source_mux, inner_lock,
        outer_lock, o_active_source};
      default: begin
        for (int i = 0; i < `NUM_PAIRS; i++) begin
          if (slot(i_wb_adr, `REG_DELAY_BASE) == 4'(i)) next_rdata = {16'h0, delay_pending[i]};
          if (slot(i_wb_adr, `REG_FMT_BASE) == 4'(i)) next_rdata = {24'h0, pair_cfg[i]};
        end
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) o_wb_dat <= 32'h0000_0000;
    else if (wb_hit && !i_wb_we) o_wb_dat <= next_rdata;
  end

  // pin mode qualification: auto off, pins on, polarity zero, both types input
  assign pin_mode = !sel_ctrl[`SEL_AUTO_BIT] && sel_ctrl[`SEL_PINEN_BIT] &&
    !sel_ctrl[`SEL_PINPOL_BIT] &&
    is_input_type(sel_ctrl[`SEL_TYPE0_LSB +: 3]) &&
    is_input_type(sel_ctrl[`SEL_TYPE1_LSB +: 3]);

  // pins left as inputs while their type is an input type; registered so the
  // pad enable never glitches while a control write settles
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_select_bit0_oe <= 1'b0;
      o_select_bit1_oe <= 1'b0;
    end else begin
      o_select_bit0_oe <= !is_input_type(sel_ctrl[`SEL_TYPE0_LSB +: 3]);
      o_select_bit1_oe <= !is_input_type(sel_ctrl[`SEL_TYPE1_LSB +: 3]);
    end
  end

  // active source; outside pin mode the last choice is kept
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      last_source <= SRC_A;
    end else if (pin_mode) begin
      case ({pin_sel1, pin_sel0})
        2'b00: last_source <= SRC_A;
        2'b01: last_source <= SRC_B;
        2'b10: last_source <= SRC_C;
        2'b11: last_source <= SRC_HOLDOVER;
        default: last_source <= SRC_A;
      endcase
    end
  end
  assign o_active_source = last_source;

  // pin sense set by polarity; invert toggle flips the sense and so makes an edge
  assign align_asserted = align_raw ^ align_ctrl[`ALIGN_POL_BIT] ^
    align_ctrl[`ALIGN_INV_BIT];
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      align_asserted_q <= 1'b0;
      inv_q <= 1'b0;
    end else begin
      align_asserted_q <= align_asserted;
      inv_q <= align_ctrl[`ALIGN_INV_BIT];
    end
  end
  // a software toggle counts even if the pin sense then reads deasserted
  assign align_event = (align_asserted && !align_asserted_q) ||
    (align_ctrl[`ALIGN_INV_BIT] != inv_q);

  // one pulse aligns all dividers enabled for it
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) o_align_pulse <= 1'b0;
    else o_align_pulse <= align_event;
  end

  // delays reach the outputs only on an alignment event
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_pair_delay <= '0;
    end else if (align_event) begin
      for (int i = 0; i < `NUM_PAIRS; i++) o_pair_delay[i*16 +: 16] <= delay_pending[i];
    end
  end

  // request enable lets the asserted pin force continuous mode
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_frame_ref_source_mux <= 2'h0;
    end else if (frame_ctrl[`FRAME_REQEN_BIT] && align_asserted) begin
      o_frame_ref_source_mux <= `FRAME_MUX_CONT;
    end else begin
      o_frame_ref_source_mux <= frame_ctrl[`FRAME_MUX_LSB +: 2];
    end
  end

  // per-pair output stage
  for (genvar g = 0; g < `NUM_PAIRS; g++) begin : g_pair
    pair_format u_fmt (
      .i_clock(i_clock),
      .i_rst_n(rst_n),
      .i_cfg(pair_cfg[g]),
      .i_hold_low(align_ctrl[`ALIGN_HOLDLOW_BIT] && align_asserted),
      .o_enable_p(o_pair_enable_p[g]),
      .o_enable_n(o_pair_enable_n[g]),
      .o_invert_p(o_pair_invert_p[g]),
      .o_invert_n(o_pair_invert_n[g]),
      .o_force_low(o_pair_force_low[g])
    );
  end

  // lock pins: high while locked, low once lost
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_lock_status_out_a <= 1'b0;
      o_lock_status_out_b <= 1'b0;
    end else begin
      o_lock_status_out_a <= outer_lock;
      o_lock_status_out_b <= inner_lock;
    end
  end
endmodule // ref_select_and_sync_control

// ### dv/refsel_monitor.sv
// checker for the clock control block, bound to its top module
`include "refsel_regs.svh"
module refsel_monitor (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic o_wb_ack,
  input wire logic i_align_pin,
  input wire logic i_ref_select_bit0,
  input wire logic i_ref_select_bit1,
  input wire logic i_outer_loop_lock,
  input wire logic i_inner_loop_lock,
  input wire refsel_pkg::ref_source_t o_active_source,
  input wire logic o_align_pulse,
  input wire logic [1:0] o_frame_ref_source_mux,
  input wire logic [`NUM_PAIRS*16-1:0] o_pair_delay,
  input wire logic o_lock_status_out_a,
  input wire logic o_lock_status_out_b
);
  import refsel_pkg::*;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  logic [2:0] up_cnt;
  logic [4:0] wr_hist;
  logic [5:0] pin_hist;
  // settle count covers the internal reset copy; histories give causes of a pulse
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      up_cnt <= 3'h0;
      wr_hist <= 5'h00;
      pin_hist <= 6'h00;
    end else begin
      up_cnt <= (up_cnt == 3'h7) ? up_cnt : up_cnt + 3'h1;
      wr_hist <= {wr_hist[3:0], o_wb_ack & i_wb_we};
      pin_hist <= {pin_hist[4:0], i_align_pin};
    end
  end
  ack_one_cycle_a: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held too long");
  ack_prompt_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("ack missing");
  ack_cause_a: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
    else $error("ack without request");
  source_pins_a: assert property (
    $changed(o_active_source) |-> o_active_source == $past({i_ref_select_bit1, i_ref_select_bit0}, 3))
    else $error("source differs from pins");
  lock_out_a_a: assert property (up_cnt == 3'h7 |->
    o_lock_status_out_a == $past(i_outer_loop_lock, 3)) else $error("outer lock pin wrong");
  lock_out_b_a: assert property (up_cnt == 3'h7 |->
    o_lock_status_out_b == $past(i_inner_loop_lock, 3)) else $error("inner lock pin wrong");
  delay_on_align_a: assert property ($changed(o_pair_delay) |-> o_align_pulse)
    else $error("delay applied without alignment");
  pulse_single_a: assert property (o_align_pulse |=> !o_align_pulse)
    else $error("alignment pulse too long");
  align_cause_a: assert property (o_align_pulse |-> |wr_hist ||
    (pin_hist[5:1] != 5'h00 && pin_hist[5:1] != 5'h1F)) else $error("pulse without cause");
  cover property ($rose(o_align_pulse));
  cover property (o_active_source == SRC_HOLDOVER);
  cover property (o_frame_ref_source_mux == `FRAME_MUX_CONT);
endmodule // refsel_monitor

bind ref_select_and_sync_control refsel_monitor mon (.i_clock, .i_resetn, .i_wb_cyc,
  .i_wb_stb, .i_wb_we, .o_wb_ack, .i_align_pin, .i_ref_select_bit0, .i_ref_select_bit1,
  .i_outer_loop_lock, .i_inner_loop_lock, .o_active_source, .o_align_pulse,
  .o_frame_ref_source_mux, .o_pair_delay, .o_lock_status_out_a, .o_lock_status_out_b);

// ### dv/refsel_host_model.sv
// host side model: drives the select, alignment and lock level pins
module refsel_host_model (
  input wire logic i_clock,
  input wire logic [4:0] i_cmd,
  output logic o_ref_select_bit0 = 1'b0,
  output logic o_ref_select_bit1 = 1'b0,
  output logic o_align_pin = 1'b0,
  output logic o_outer_loop_lock = 1'b0,
  output logic o_inner_loop_lock = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // pins move just after an edge, never between, like a clocked host port
  always @(posedge i_clock) begin
    {o_inner_loop_lock, o_outer_loop_lock, o_align_pin, o_ref_select_bit1,
      o_ref_select_bit0} <= i_cmd;
  end
endmodule // refsel_host_model

// ### dv/ref_select_and_sync_control_tb.sv
// self-checking bench for the clock control block
`include "refsel_regs.svh"
module ref_select_and_sync_control_tb import refsel_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock = 1'b0;
  logic i_resetn = 1'b0;
  logic i_wb_cyc = 1'b0;
  logic i_wb_stb = 1'b0;
  logic i_wb_we = 1'b0;
  logic [7:0] i_wb_adr = 8'h00;
  logic [3:0] i_wb_sel = 4'h0;
  logic [31:0] i_wb_dat = 32'h0, o_wb_dat, q;
  logic o_wb_ack, i_ref_select_bit0, i_ref_select_bit1, i_align_pin;
  logic i_outer_loop_lock, i_inner_loop_lock, o_select_bit0_oe, o_select_bit1_oe;
  logic o_align_pulse, o_lock_status_out_a, o_lock_status_out_b;
  logic [1:0] o_frame_ref_source_mux;
  logic [`NUM_PAIRS*16-1:0] o_pair_delay;
  logic [`NUM_PAIRS-1:0] o_pair_enable_p, o_pair_enable_n, o_pair_invert_p, o_pair_invert_n;
  logic [`NUM_PAIRS-1:0] o_pair_force_low;
  logic [4:0] cmd = 5'h00;
  logic [31:0] bad [5] = '{32'h3, 32'h0, 32'h6, 32'h42, 32'h402};
  ref_source_t o_active_source;
  int error_cnt = 0;
  int n_checks = 0;
  int pulses = 0;
  ref_select_and_sync_control dut (.*);
  refsel_host_model host (.i_clock, .i_cmd(cmd), .o_ref_select_bit0(i_ref_select_bit0),
    .o_ref_select_bit1(i_ref_select_bit1), .o_align_pin(i_align_pin),
    .o_outer_loop_lock(i_outer_loop_lock), .o_inner_loop_lock(i_inner_loop_lock));
  // 50 MHz clock
  initial begin
    forever #10 i_clock = ~i_clock;
  end
  // alignment pulses are counted, so a doubled or missing one shows
  always @(posedge i_clock) begin
    if (o_align_pulse === 1'b1)
      pulses++;
  end
  task automatic end_sim;
    $display("Checks %0d, errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one classic cycle; the wait is bounded so a dead slave cannot hang us
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d,
                    output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge i_clock);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= we;
    i_wb_adr <= adr;
    i_wb_dat <= d;
    i_wb_sel <= 4'hF;
    do begin
      @(posedge i_clock);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 20);
    rd = o_wb_dat;
    chk(n < 20, 1'b1);
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
  endtask
  // waits n cycles, then checks the number of alignment pulses seen
  task automatic idle(input int n, input int p);
    int b;
    b = pulses;
    repeat (n) @(posedge i_clock);
    #1;
    chk(pulses - b, p);
  endtask
  // watchdog: the tests take well under 2000 cycles
  initial begin
    #100us;
    error_cnt++;
    end_sim;
  end
  initial begin
    repeat (3) @(posedge i_clock);
    i_resetn <= 1'b1;
    repeat (3) @(posedge i_clock);
    chk({o_select_bit1_oe, o_select_bit0_oe}, 2'b00);
    wb(1'b0, `REG_SEL_CTRL, 32'h0, q);
    chk(q, `SEL_CTRL_RESET);
    for (int k = 0; k < 4; k++) begin
      cmd[1:0] <= k[1:0];
      idle(6, 0);
      chk(o_active_source, k);
      wb(1'b0, `REG_STATUS, 32'h0, q);
      chk(q[1:0], k);
    end
    // leave pin mode before moving the pins, so the source must hold
    wb(1'b1, `REG_SEL_CTRL, 32'h3, q);
    cmd[1:0] <= 2'b01;
    foreach (bad[i]) begin
      wb(1'b1, `REG_SEL_CTRL, bad[i], q);
      idle(6, 0);
      chk(o_active_source, SRC_HOLDOVER);
      chk({o_select_bit1_oe, o_select_bit0_oe}, {bad[i][10], bad[i][6]});
    end
    wb(1'b1, `REG_SEL_CTRL, `SEL_CTRL_RESET, q);
    idle(6, 0);
    chk(o_active_source, SRC_B);
    cmd[4:3] <= 2'b01;
    idle(6, 0);
    chk({o_lock_status_out_b, o_lock_status_out_a}, 2'b01);
    cmd[4:3] <= 2'b10;
    idle(6, 0);
    chk({o_lock_status_out_b, o_lock_status_out_a}, 2'b10);
    wb(1'b1, 8'hFC, 32'hFFFF_FFFF, q);
    wb(1'b0, 8'hFC, 32'h0, q);
    chk(q, 32'h0);
    wb(1'b1, `REG_FRAME_CTRL, 32'h10, q);
    wb(1'b1, `REG_DELAY_BASE, 32'h1234, q);
    idle(4, 0);
    chk(o_pair_delay[15:0], 16'h0);
    cmd[2] <= 1'b1;
    idle(8, 1);
    chk(o_pair_delay[15:0], 16'h1234);
    chk(o_frame_ref_source_mux, `FRAME_MUX_CONT);
    cmd[2] <= 1'b0;
    idle(8, 0);
    chk(o_frame_ref_source_mux, 2'h0);
    wb(1'b1, `REG_ALIGN_CTRL, 32'h2, q);
    idle(8, 1);
    chk(o_frame_ref_source_mux, `FRAME_MUX_CONT);
    wb(1'b1, `REG_ALIGN_CTRL, 32'h1, q);
    idle(8, 1);
    cmd[2] <= 1'b1;
    idle(8, 0);
    cmd[2] <= 1'b0;
    idle(8, 1);
    wb(1'b1, `REG_ALIGN_CTRL, 32'h4, q);
    idle(8, 0);
    cmd[2] <= 1'b1;
    idle(8, 1);
    chk(o_pair_force_low, 7'h7F);
    cmd[2] <= 1'b0;
    idle(8, 0);
    chk(o_pair_force_low, 7'h00);
    wb(1'b1, `REG_FMT_BASE, 32'h96, q);
    wb(1'b1, `REG_FMT_BASE + 8'h4, 32'h01, q);
    wb(1'b1, `REG_FMT_BASE + 8'h8, 32'h86, q);
    idle(3, 0);
    chk({o_pair_enable_n[2:0], o_pair_enable_p[2:0]}, 6'b111_011);
    chk({o_pair_invert_n[2:0], o_pair_invert_p[2:0]}, 6'b111_000);
    end_sim;
  end
endmodule // ref_select_and_sync_control_tb
